// ==== sps_pkg.sv ====
// Constants and types shared by the SPI port

package sps_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SPS_OFF_CTRL = 8'h00;
  localparam logic [7:0] SPS_OFF_STAT = 8'h04;
  localparam logic [7:0] SPS_OFF_DATA = 8'h08;
  localparam logic [7:0] SPS_OFF_AUX  = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SPS_B_IRQ_EN = 7;
  localparam int SPS_B_PEN    = 6;
  localparam int SPS_B_LSB    = 5;
  localparam int SPS_B_MASTER_SELECT   = 4;
  localparam int SPS_B_CLOCK_POLARITY   = 3;
  localparam int SPS_B_CLOCK_PHASE   = 2;
  localparam int SPS_B_DONE   = 7;
  localparam int SPS_B_WRITE_COLLISION_FLAG   = 6;
  localparam int SPS_B_DBL    = 0;
  localparam int SPS_B_SSIN   = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SPS_RST_CTRL = 8'h00;
  localparam logic       SPS_RST_SSIN = 1'b1;

  // ----------------------------------------------------------------
  // Half SCK periods in system clocks
  // ----------------------------------------------------------------
  localparam logic [6:0] SPS_HALF_DIV2   = 7'h01;
  localparam logic [6:0] SPS_HALF_DIV4   = 7'h02;
  localparam logic [6:0] SPS_HALF_DIV8   = 7'h04;
  localparam logic [6:0] SPS_HALF_DIV16  = 7'h08;
  localparam logic [6:0] SPS_HALF_DIV32  = 7'h10;
  localparam logic [6:0] SPS_HALF_DIV64  = 7'h20;
  localparam logic [6:0] SPS_HALF_DIV128 = 7'h40;
  localparam logic [3:0] SPS_LAST_EDGE   = 4'hf;
  localparam logic [3:0] SPS_LAST_SAMPLE = 4'h7;

  typedef enum logic [0:0] {
    SPS_IDLE = 1'b0,
    SPS_BUSY = 1'b1
  } sps_state_t;

endpackage

// ==== sps_port.sv ====
// SPI master/slave port with AHB-Lite register access
`timescale 1ns/10ps

module sps_port (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // CPU side
  input  wire logic        cpu_irq_enable,
  input  wire logic        irq_vector_ack,
  output logic             spi_irq,
  // SPI pins
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i
);
  import sps_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic        dbl_r;
  logic        done_r;
  logic        write_collision_flag_r;
  logic        arm_r;
  logic        ssin_r;
  logic [7:0]  rx_buf_r;
  logic [7:0]  sh_r;
  logic [7:0]  sh_nxt;
  logic        dout_r;
  logic        sck_r;
  logic        sck_prev_r;
  logic [6:0]  div_r;
  logic [3:0]  edge_r;
  logic [3:0]  nsamp_r;
  sps_state_t  state_r;
  logic [7:0]  ap_addr_r;
  logic        ap_wr_r;
  logic        rd_pend_r;
  logic        hready_r;
  logic [31:0] hrdata_r;
  logic        irq_r;
  logic        sck_oe_r;
  logic        mosi_oe_r;
  logic        miso_oe_r;

  logic        en;
  logic        master;
  logic        clock_polarity;
  logic        clock_phase;
  logic        lsb;
  logic        slave_sel;
  logic        mode_fault;
  logic [6:0]  half;
  logic        wr_ev;
  logic        rd_ev;
  logic        data_wr;
  logic        data_acc;
  logic        stat_rd;
  logic        load_ok;
  logic        edge_ev;
  logic        lead;
  logic        sample_ev;
  logic        setup_ev;
  logic        din;
  logic        byte_done;
  logic        done_set;
  logic        done_clr;
  logic        eng_reset;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic out_bit(input logic [7:0] d, input logic lsb_first);
    out_bit = lsb_first ? d[0] : d[7];
  endfunction

  function automatic logic [6:0] half_of(input logic [1:0] rate, input logic dbl);
    case ({dbl, rate})
      3'b000:  half_of = SPS_HALF_DIV4;
      3'b001:  half_of = SPS_HALF_DIV16;
      3'b010:  half_of = SPS_HALF_DIV64;
      3'b011:  half_of = SPS_HALF_DIV128;
      3'b100:  half_of = SPS_HALF_DIV2;
      3'b101:  half_of = SPS_HALF_DIV8;
      3'b110:  half_of = SPS_HALF_DIV32;
      default: half_of = SPS_HALF_DIV64;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign en         = ctrl_r[SPS_B_PEN];
  assign master     = ctrl_r[SPS_B_MASTER_SELECT];
  assign clock_polarity       = ctrl_r[SPS_B_CLOCK_POLARITY];
  assign clock_phase       = ctrl_r[SPS_B_CLOCK_PHASE];
  assign lsb        = ctrl_r[SPS_B_LSB];
  assign slave_sel  = en & ~master & ~ss_n_i;
  assign mode_fault = en & master & ssin_r & ~ss_n_i;
  assign half       = half_of(ctrl_r[1:0], dbl_r);

  assign wr_ev    = ap_wr_r;
  assign rd_ev    = rd_pend_r;
  assign data_wr  = wr_ev & hit(ap_addr_r, SPS_OFF_DATA);
  assign data_acc = (wr_ev | rd_ev) & hit(ap_addr_r, SPS_OFF_DATA);
  assign stat_rd  = rd_ev & hit(ap_addr_r, SPS_OFF_STAT);
  assign load_ok  = data_wr & en & (state_r == SPS_IDLE);

  // Slave edges come from the pin, master edges from the divider
  assign edge_ev  = master ? (en & (state_r == SPS_BUSY) & (div_r == half - 7'h01))
                           : (slave_sel & (sck_i != sck_prev_r));
  assign lead     = master ? ~edge_r[0] : (sck_prev_r == clock_polarity);
  assign sample_ev = edge_ev & (lead ^ clock_phase);
  assign setup_ev  = edge_ev & ~(lead ^ clock_phase);
  assign din       = master ? miso_i : mosi_i;
  assign sh_nxt    = lsb ? {din, sh_r[7:1]} : {sh_r[6:0], din};
  assign byte_done = sample_ev & (nsamp_r == SPS_LAST_SAMPLE);
  assign done_set  = byte_done | mode_fault;
  assign done_clr  = irq_vector_ack | (data_acc & arm_r);
  // Disabled port, deselected slave or mode fault drop any partial byte
  assign eng_reset = ~en | (~master & ss_n_i) | mode_fault;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Reads take one wait state so read data leaves a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_addr_r <= 8'h00;
      ap_wr_r   <= 1'b0;
      rd_pend_r <= 1'b0;
      hready_r  <= 1'b1;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      ap_wr_r   <= 1'b0;
      rd_pend_r <= 1'b0;
      hready_r  <= 1'b1;
      if (hsel && hready && htrans[1]) begin
        ap_addr_r <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
        ap_wr_r   <= hwrite;
        rd_pend_r <= ~hwrite;
        hready_r  <= hwrite;
      end
      if (rd_pend_r) begin
        case (ap_addr_r)
          SPS_OFF_CTRL: hrdata_r <= {24'h00_0000, ctrl_r};
          SPS_OFF_STAT: hrdata_r <= {24'h00_0000, done_r, write_collision_flag_r, 5'h00, dbl_r};
          SPS_OFF_DATA: hrdata_r <= {24'h00_0000, rx_buf_r};
          SPS_OFF_AUX:  hrdata_r <= {31'h0000_0000, ssin_r};
          default:      hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= SPS_RST_CTRL;
      dbl_r  <= 1'b0;
      ssin_r <= SPS_RST_SSIN;
    end else begin
      if (wr_ev && hit(ap_addr_r, SPS_OFF_CTRL)) ctrl_r <= hwdata[7:0];
      if (wr_ev && hit(ap_addr_r, SPS_OFF_STAT)) dbl_r <= hwdata[SPS_B_DBL];
      if (wr_ev && hit(ap_addr_r, SPS_OFF_AUX))  ssin_r <= hwdata[SPS_B_SSIN];
      // Fault wins over a software write in the same cycle
      if (mode_fault) ctrl_r[SPS_B_MASTER_SELECT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      arm_r  <= 1'b0;
    end else begin
      done_r <= done_set | (done_r & ~done_clr);
      write_collision_flag_r <= (data_wr & en & (state_r == SPS_BUSY))
              | (write_collision_flag_r & ~(data_acc & arm_r));
      if (stat_rd) arm_r <= done_r | write_collision_flag_r;
      else if (data_acc) arm_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= SPS_IDLE;
      sh_r       <= 8'h00;
      rx_buf_r   <= 8'h00;
      dout_r     <= 1'b0;
      sck_r      <= 1'b0;
      sck_prev_r <= 1'b0;
      div_r      <= 7'h00;
      edge_r     <= 4'h0;
      nsamp_r    <= 4'h0;
    end else begin
      sck_prev_r <= sck_i;
      if (eng_reset) begin
        state_r <= SPS_IDLE;
        div_r   <= 7'h00;
        edge_r  <= 4'h0;
        nsamp_r <= 4'h0;
        sck_r   <= clock_polarity;
        if (load_ok) begin
          sh_r   <= hwdata[7:0];
          dout_r <= out_bit(hwdata[7:0], lsb);
        end else begin
          dout_r <= out_bit(sh_r, lsb);
        end
      end else begin
        if (state_r == SPS_IDLE) sck_r <= clock_polarity;
        if (load_ok) begin
          sh_r    <= hwdata[7:0];
          dout_r  <= out_bit(hwdata[7:0], lsb);
          edge_r  <= 4'h0;
          nsamp_r <= 4'h0;
          div_r   <= 7'h00;
          if (master) state_r <= SPS_BUSY;
        end else begin
          if (!master && edge_ev) state_r <= SPS_BUSY;
          if (master && state_r == SPS_BUSY) begin
            if (edge_ev) begin
              div_r  <= 7'h00;
              sck_r  <= ~sck_r;
              edge_r <= edge_r + 4'h1;
              if (edge_r == SPS_LAST_EDGE) state_r <= SPS_IDLE;
            end else begin
              div_r <= div_r + 7'h01;
            end
          end
          if (sample_ev) begin
            sh_r    <= sh_nxt;
            nsamp_r <= nsamp_r + 4'h1;
          end
          if (setup_ev) dout_r <= out_bit(sh_r, lsb);
          if (byte_done) begin
            rx_buf_r <= sh_nxt;
            nsamp_r  <= 4'h0;
            if (!master) state_r <= SPS_IDLE;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin enables and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_oe_r  <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      sck_oe_r  <= en & master & ~mode_fault;
      mosi_oe_r <= en & master & ~mode_fault;
      miso_oe_r <= slave_sel;
      irq_r     <= done_r & ctrl_r[SPS_B_IRQ_EN] & cpu_irq_enable;
    end
  end

  assign hreadyout = hready_r;
  assign hrdata    = hrdata_r;
  assign hresp     = 1'b0;
  assign spi_irq   = irq_r;
  assign sck_o     = sck_r;
  assign sck_oe    = sck_oe_r;
  assign mosi_o    = dout_r;
  assign mosi_oe   = mosi_oe_r;
  assign miso_o    = dout_r;
  assign miso_oe   = miso_oe_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [6:0] gap_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_r <= 7'h00;
    else if (sck_r != $past(sck_r)) gap_r <= 7'h01;
    else if (gap_r != 7'h7f) gap_r <= gap_r + 7'h01;
  end

  property p_irq;
    done_r && ctrl_r[SPS_B_IRQ_EN] && cpu_irq_enable |=> spi_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_disabled_idle;
    !en |=> state_r == SPS_IDLE && !sck_oe && !miso_oe;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("active while off");

  property p_mode_fault;
    mode_fault |=> !master && done_r ##1 !sck_oe;
  endproperty
  a_mode_fault: assert property (p_mode_fault) else $error("mode fault missed");

  property p_idle_level;
    state_r == SPS_IDLE ##1 state_r == SPS_IDLE |-> sck_o == $past(clock_polarity);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("sck idle level");

  property p_sck_rate;
    master && state_r == SPS_BUSY && $past(state_r) == SPS_BUSY
      && $changed(sck_r) && edge_r > 4'h1 |-> gap_r == half;
  endproperty
  a_sck_rate: assert property (p_sck_rate) else $error("sck half period");

  property p_collision;
    data_wr && en && state_r == SPS_BUSY |=> write_collision_flag_r;
  endproperty
  a_collision: assert property (p_collision) else $error("collision flag");

  property p_reserved;
    $rose(hready_r) && $past(rd_pend_r) && $past(ap_addr_r) == SPS_OFF_STAT
      |-> hrdata[5:1] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_rx_update;
    byte_done |=> done_r && rx_buf_r == $past(sh_nxt);
  endproperty
  a_rx_update: assert property (p_rx_update) else $error("rx buffer");

  property p_slave_drop;
    en && !master && ss_n_i |=> nsamp_r == 4'h0 && state_r == SPS_IDLE;
  endproperty
  a_slave_drop: assert property (p_slave_drop) else $error("slave not reset");

  property p_flag_clear;
    data_acc && arm_r && !done_set && !(data_wr && en && state_r == SPS_BUSY)
      |=> !done_r && !write_collision_flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

  property p_start;
    load_ok && master && !eng_reset |=> state_r == SPS_BUSY;
  endproperty
  a_start: assert property (p_start) else $error("master did not start");

  c_master_byte: cover property (master && byte_done);
  c_slave_byte:  cover property (!master && byte_done);
  c_fault:       cover property (mode_fault);
  c_collision:   cover property (data_wr && state_r == SPS_BUSY);

endmodule

// ==== sps_spi_peer.sv ====
// Behavioural far-side SPI device, slave or master
`timescale 1ns/10ps

module sps_spi_peer (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Setup from the bench
  input  wire logic       as_master,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       lsb_first,
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  input  wire logic [4:0] stop_edges,
  input  wire logic [3:0] half,
  // Pins
  input  wire logic       dut_sck,
  input  wire logic       data_in,
  output logic            sck,
  output logic            ss_n,
  output logic            data_out,
  output logic [7:0]      rx_byte
);
  logic       active_r;
  logic       prev_r;
  logic       junk_r;
  logic       line;
  logic [3:0] samples_r;
  logic [3:0] cnt_r;
  logic [4:0] edges_r;
  logic [2:0] idx;

  assign line = as_master ? sck : dut_sck;
  assign idx = lsb_first ? samples_r[2:0] : 3'h7 - samples_r[2:0];
  // Released line toggles so a stale bit never passes for data
  assign data_out = active_r ? tx_byte[idx] : junk_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_r <= 1'b0;
      prev_r <= 1'b0;
      junk_r <= 1'b0;
      sck <= 1'b0;
      ss_n <= 1'b1;
      samples_r <= 4'h0;
      cnt_r <= 4'h0;
      edges_r <= 5'h00;
      rx_byte <= 8'h00;
    end else begin
      prev_r <= line;
      junk_r <= ~junk_r;
      if (go) begin
        active_r <= 1'b1;
        samples_r <= 4'h0;
        cnt_r <= 4'h0;
        edges_r <= 5'h00;
        ss_n <= ~as_master;
      end else if (active_r) begin
        if (line != prev_r && ((line != clock_polarity) != clock_phase)) begin
          samples_r <= samples_r + 4'h1;
          rx_byte <= lsb_first ? {data_in, rx_byte[7:1]} : {rx_byte[6:0], data_in};
        end
        if (!as_master)
          active_r <= (samples_r != 4'h8);
        else if (cnt_r != half - 4'h1)
          cnt_r <= cnt_r + 4'h1;
        else if (edges_r == stop_edges) begin
          active_r <= 1'b0;
          ss_n <= 1'b1;
        end else begin
          // Half period of two or more clocks keeps SCK at or below a quarter rate
          cnt_r <= 4'h0;
          sck <= ~sck;
          edges_r <= edges_r + 5'h01;
        end
      end else
        sck <= clock_polarity;
    end
  end
endmodule

// ==== spi_master_slave_port_tb_top.sv ====
// Self-checking bench for the SPI port
`timescale 1ns/10ps

module spi_master_slave_port_tb_top;
  import sps_pkg::*;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rdat;
  logic        hreadyout, hresp, spi_irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic        cpu_irq_enable = 1'b0;
  logic        irq_vector_ack = 1'b0;
  logic        tb_ss_n = 1'b1;
  logic        p_master = 1'b0, p_go = 1'b0, clock_polarity = 1'b0, clock_phase = 1'b0, lsb = 1'b0;
  logic        p_sck, p_ss_n, p_dout, p_din, sck_d;
  logic [7:0]  p_tx = 8'h00;
  logic [7:0]  p_rx;
  logic [4:0]  p_stop = 5'h10;
  logic [3:0]  p_half = 4'h2;
  int          fails = 0, check_count = 0, cyc = 0, last_tog = 0, min_half = 999;
  bit          tog_seen = 1'b0;
  int          divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};

  initial begin
    forever #4 hclk = ~hclk;
  end

  assign p_din = p_master ? miso_o : mosi_o;

  sps_port uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .cpu_irq_enable(cpu_irq_enable), .irq_vector_ack(irq_vector_ack), .spi_irq(spi_irq),
    .sck_i(p_sck), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(p_dout), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(p_dout), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(p_ss_n & tb_ss_n));

  sps_spi_peer peer (
    .hclk(hclk), .hresetn(hresetn), .as_master(p_master), .clock_polarity(clock_polarity), .clock_phase(clock_phase),
    .lsb_first(lsb), .go(p_go), .tx_byte(p_tx), .stop_edges(p_stop), .half(p_half),
    .dut_sck(sck_o), .data_in(p_din), .sck(p_sck), .ss_n(p_ss_n), .data_out(p_dout),
    .rx_byte(p_rx));

  // Shortest SCK half period seen since the last restart
  always @(posedge hclk) begin
    cyc++;
    if (sck_o !== sck_d) begin
      if (tog_seen && cyc - last_tog < min_half)
        min_half = cyc - last_tog;
      tog_seen = 1'b1;
      last_tog = cyc;
    end
    sck_d = sck_o;
  end

  task complete_run;
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task hang;
    fails++;
    complete_run;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
      hang;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    rdat = hrdata;
    if (hreadyout !== 1'b1)
      hang;
  endtask

  task wait_done;
    int n;
    n = 0;
    do begin
      bus(1'b0, SPS_OFF_STAT, 32'h0);
      n++;
    end while (rdat[SPS_B_DONE] !== 1'b1 && n < 600);
    if (rdat[SPS_B_DONE] !== 1'b1)
      hang;
  endtask

  task go_peer;
    p_go <= 1'b1;
    @(posedge hclk);
    p_go <= 1'b0;
  endtask

  task wait_peer;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (p_ss_n !== 1'b1 && n < 400);
    if (p_ss_n !== 1'b1)
      hang;
  endtask

  initial begin
    int n;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // --------------------------------
    // Reset state and a disabled port
    // --------------------------------
    bus(1'b0, SPS_OFF_CTRL, 32'h0);
    chk("ctrl reset", rdat, 32'h0);
    chk("hresp okay", 32'(hresp), 32'h0);
    bus(1'b0, SPS_OFF_STAT, 32'h0);
    chk("status reserved", rdat & 32'h3e, 32'h0);
    bus(1'b1, 8'h10, 32'hff);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", rdat, 32'h0);
    bus(1'b1, SPS_OFF_DATA, 32'h5a);
    repeat (40) @(posedge hclk);
    chk("disabled sck_oe", 32'(sck_oe), 32'h0);
    bus(1'b0, SPS_OFF_STAT, 32'h0);
    chk("disabled done", rdat & 32'h80, 32'h0);
    // --------------------------------
    // Master: all modes, orders, rates
    // --------------------------------
    for (int i = 0; i < 8; i++) begin
      p_master <= 1'b0;
      clock_polarity <= i[1];
      clock_phase <= i[0];
      lsb <= i[2] ^ i[0];
      p_tx <= 8'h3c ^ 8'(i);
      bus(1'b1, SPS_OFF_CTRL, {24'h0, 2'b01, i[2] ^ i[0], 1'b1, i[1], i[0], i[1], i[0]});
      bus(1'b1, SPS_OFF_STAT, {31'h0, i[2]});
      go_peer;
      tog_seen = 1'b0;
      min_half = 999;
      bus(1'b1, SPS_OFF_DATA, 32'hc5 ^ i);
      if (i == 0) begin
        bus(1'b1, SPS_OFF_DATA, 32'h0f);
        bus(1'b0, SPS_OFF_STAT, 32'h0);
        chk("collision", rdat & 32'hc0, 32'h40);
      end
      wait_done;
      chk("status low", rdat & 32'h3f, i >> 2);
      bus(1'b0, SPS_OFF_DATA, 32'h0);
      chk("received", rdat, 32'(p_tx));
      chk("peer got", 32'(p_rx), 32'hc5 ^ i);
      chk("half period", min_half, divs[i] / 2);
      bus(1'b0, SPS_OFF_STAT, 32'h0);
      chk("flags cleared", rdat & 32'hc0, 32'h0);
      n = 0;
      while (sck_o !== i[1] && n < 200) begin
        @(posedge hclk);
        n++;
      end
      chk("sck idle", 32'(sck_o), 32'(i[1]));
      chk("master pins", {30'h0, sck_oe, mosi_oe}, 32'h3);
    end
    // Interrupt: masked, raised, acknowledged
    clock_polarity <= 1'b0;
    clock_phase <= 1'b0;
    bus(1'b1, SPS_OFF_CTRL, 32'hd0);
    go_peer;
    bus(1'b1, SPS_OFF_DATA, 32'h81);
    wait_done;
    chk("irq masked", 32'(spi_irq), 32'h0);
    cpu_irq_enable <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("irq raised", 32'(spi_irq), 32'h1);
    irq_vector_ack <= 1'b1;
    @(posedge hclk);
    irq_vector_ack <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("irq acked", 32'(spi_irq), 32'h0);
    bus(1'b0, SPS_OFF_STAT, 32'h0);
    chk("done acked", rdat & 32'h80, 32'h0);
    // Mode fault from slave select
    bus(1'b1, SPS_OFF_AUX, 32'h1);
    tb_ss_n <= 1'b0;
    repeat (3) @(posedge hclk);
    tb_ss_n <= 1'b1;
    bus(1'b0, SPS_OFF_CTRL, 32'h0);
    chk("fault ctrl", rdat, 32'hc0);
    bus(1'b0, SPS_OFF_STAT, 32'h0);
    chk("fault done", rdat & 32'h80, 32'h80);
    chk("fault irq", 32'(spi_irq), 32'h1);
    bus(1'b0, SPS_OFF_DATA, 32'h0);
    cpu_irq_enable <= 1'b0;
    // Slave under the peer, aborted frame first
    for (int j = 0; j < 2; j++) begin
      p_master <= 1'b1;
      clock_polarity <= ~j[0];
      clock_phase <= j[0];
      lsb <= j[0];
      p_half <= j[0] ? 4'h4 : 4'h2;
      bus(1'b1, SPS_OFF_CTRL, {24'h0, 2'b01, j[0], 1'b0, ~j[0], j[0], 2'b11});
      p_stop <= 5'h06;
      go_peer;
      wait_peer;
      p_stop <= 5'h10;
      p_tx <= 8'h6e ^ 8'(j);
      bus(1'b1, SPS_OFF_DATA, 32'ha7 ^ j);
      go_peer;
      repeat (2) @(posedge hclk);
      chk("slave miso_oe", 32'(miso_oe), 32'h1);
      wait_peer;
      wait_done;
      bus(1'b0, SPS_OFF_DATA, 32'h0);
      chk("slave received", rdat, 32'(p_tx));
      chk("slave sent", 32'(p_rx), 32'ha7 ^ j);
      chk("slave pins", {29'h0, miso_oe, sck_oe, mosi_oe}, 32'h0);
    end
    complete_run;
  end
endmodule
